// file: logic/adcai_top.sv
// APB slave and top level of the averaging and interrupt control block.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "adcai_defines.svh"
module adcai_top #(
    parameter int DATA_W = 12,
    parameter int CHAN_W = 5
) (
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [7:0]        paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    input  wire logic              conv_valid_in,
    input  wire logic [DATA_W-1:0] conv_data_in,
    input  wire logic [CHAN_W-1:0] conv_chan_in,
    input  wire logic [1:0]        conv_seq_in,
    input  wire logic [3:0]        done_evt_in,
    input  wire logic [3:0]        dma_evt_in,
    input  wire logic [3:0]        cmp_evt_in,
    output logic                   fifo_push_out,
    output logic [DATA_W-1:0]      fifo_data_out,
    output logic [CHAN_W-1:0]      fifo_chan_out,
    output logic [1:0]             fifo_seq_out,
    output logic                   irq_out
);
    //------------------------------------------------------------------------------------
    // Register decode
    //------------------------------------------------------------------------------------

    // Turns a byte address into a one-hot register select; zero means unmapped.
    function automatic adcai_pkg::adcai_sel_t adcai_decode(input logic [7:0] addr);
        adcai_pkg::adcai_sel_t sel;
        sel = 8'h00;
        unique case (addr)
            `ADCAI_OFS_CTRL:       sel = 8'h01;
            `ADCAI_OFS_IRQ_EN:     sel = 8'h02;
            `ADCAI_OFS_IRQ_EN_SET: sel = 8'h04;
            `ADCAI_OFS_IRQ_EN_CLR: sel = 8'h08;
            `ADCAI_OFS_RAW_STAT:   sel = 8'h10;
            `ADCAI_OFS_MSK_STAT:   sel = 8'h20;
            `ADCAI_OFS_IRQ_CLR:    sel = 8'h40;
            `ADCAI_OFS_STAT_VIEW:  sel = 8'h80;
            default:               sel = 8'h00;
        endcase
        return sel;
    endfunction

    // Expands the two low byte strobes into a mask over the twelve source bits.
    function automatic logic [11:0] adcai_lane_mask(input logic [3:0] strb);
        return {{4{strb[1]}}, {8{strb[0]}}};
    endfunction

    //------------------------------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------------------------------

    adcai_pkg::adcai_bus_state_e state_q, state_d;
    logic [31:0]            prdata_q, prdata_d;
    logic                   pready_q, pready_d;
    logic                   pslverr_q, pslverr_d;
    logic [2:0]             factor_q, factor_d;
    logic                   view_q, view_d;
    logic [11:0]            en_q, en_d;
    logic [11:0]            clr_pulse;
    logic [11:0]            evt_all;
    logic [11:0]            pending;
    logic [11:0]            masked;
    logic [11:0]            wmask;
    logic [2:0]             wfactor;
    adcai_pkg::adcai_sel_t  sel;
    logic                   commit;

    //------------------------------------------------------------------------------------
    // Interrupt sources
    //------------------------------------------------------------------------------------

    // Gathers the twelve sources into one vector: done, DMA and comparator per sequence.
    always_comb begin
        evt_all = '0;
        evt_all[`ADCAI_SRC_DONE_LSB +: 4] = done_evt_in;
        evt_all[`ADCAI_SRC_DMA_LSB +: 4]  = dma_evt_in;
        evt_all[`ADCAI_SRC_CMP_LSB +: 4]  = cmp_evt_in;
    end

    // Masked view keeps only pending flags whose enable is set.
    assign masked = pending & en_q;

    //------------------------------------------------------------------------------------
    // APB slave
    //------------------------------------------------------------------------------------

    // Every access waits one cycle; the write lands when ready is seen high.
    assign sel     = adcai_decode(paddr_in);
    assign commit  = (state_q == adcai_pkg::ST_RESP) && psel_in && penable_in;
    assign wmask   = adcai_lane_mask(pstrb_in);
    assign wfactor = pwdata_in[`ADCAI_CTRL_FACT_MSB:`ADCAI_CTRL_FACT_LSB];

    // Computes the bus state, the read answer and the register updates.
    always_comb begin
        state_d   = state_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        factor_d  = factor_q;
        view_d    = view_q;
        en_d      = en_q;
        clr_pulse = '0;
        unique case (state_q)
            adcai_pkg::ST_IDLE: begin
                if (psel_in && penable_in) begin
                    state_d   = adcai_pkg::ST_RESP;
                    pready_d  = 1'b1;
                    pslverr_d = (sel == 8'h00);
                    prdata_d  = 32'h0000_0000;
                    if (!pwrite_in) begin
                        if (sel[0]) begin
                            prdata_d[`ADCAI_CTRL_FACT_MSB:`ADCAI_CTRL_FACT_LSB] = factor_q;
                            prdata_d[`ADCAI_CTRL_VIEW_BIT] = view_q;
                        end
                        if (sel[1]) begin
                            prdata_d[11:0] = en_q;
                        end
                        if (sel[4]) begin
                            prdata_d[11:0] = pending;
                        end
                        if (sel[5]) begin
                            prdata_d[11:0] = masked;
                        end
                        if (sel[7]) begin
                            prdata_d[11:0] = view_q ? masked : pending;
                        end
                    end
                end
            end
            adcai_pkg::ST_RESP: begin
                state_d  = adcai_pkg::ST_IDLE;
                pready_d = 1'b0;
                if (commit && pwrite_in) begin
                    if (sel[0] && pstrb_in[0] && wfactor <= `ADCAI_FACT_MAX) begin
                        factor_d = wfactor;
                    end
                    if (sel[0] && pstrb_in[1]) begin
                        view_d = pwdata_in[`ADCAI_CTRL_VIEW_BIT];
                    end
                    if (sel[1]) begin
                        en_d = (en_q & ~wmask) | (pwdata_in[11:0] & wmask);
                    end
                    if (sel[2]) begin
                        en_d = en_q | (pwdata_in[11:0] & wmask);
                    end
                    if (sel[3]) begin
                        en_d = en_q & ~(pwdata_in[11:0] & wmask);
                    end
                    if (sel[6]) begin
                        clr_pulse = pwdata_in[11:0] & wmask;
                    end
                end
            end
        endcase
    end

    // Registers the bus state, the answer and the control registers.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_q   <= adcai_pkg::ST_IDLE;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            factor_q  <= `ADCAI_RST_FACT;
            view_q    <= `ADCAI_RST_VIEW;
            en_q      <= `ADCAI_RST_IRQ_EN;
        end else begin
            state_q   <= state_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            factor_q  <= factor_d;
            view_q    <= view_d;
            en_q      <= en_d;
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;

    //------------------------------------------------------------------------------------
    // Averaging and interrupt units
    //------------------------------------------------------------------------------------

    // One averaging unit serves every sequencer with the single factor setting.
    adcai_avg #(
        .DATA_W (DATA_W),
        .CHAN_W (CHAN_W)
    ) u_avg (
        .mclk_in       (mclk_in),
        .sys_rst_in    (sys_rst_in),
        .factor_in     (factor_q),
        .conv_valid_in (conv_valid_in),
        .conv_data_in  (conv_data_in),
        .conv_chan_in  (conv_chan_in),
        .conv_seq_in   (conv_seq_in),
        .res_valid_out (fifo_push_out),
        .res_data_out  (fifo_data_out),
        .res_chan_out  (fifo_chan_out),
        .res_seq_out   (fifo_seq_out)
    );

    // Pending flags with enable gating onto the single interrupt line.
    adcai_irq #(
        .N_SRC (12)
    ) u_irq (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .evt_in      (evt_all),
        .clr_in      (clr_pulse),
        .en_in       (en_q),
        .pending_out (pending),
        .irq_out     (irq_out)
    );

    //------------------------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------------------------

    // A ready answer lasts one cycle and follows an access phase.
    property p_ready_one;
        @(posedge mclk_in) disable iff (sys_rst_in)
        psel_in && penable_in && !pready_q |=> pready_q ##1 !pready_q;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("Ready not one cycle.");

    // The masked status read returns raw flags gated by enables.
    property p_masked_read;
        @(posedge mclk_in) disable iff (sys_rst_in)
        state_q == adcai_pkg::ST_IDLE && psel_in && penable_in && !pwrite_in &&
        paddr_in == `ADCAI_OFS_MSK_STAT |=> prdata_q[11:0] == ($past(pending) & $past(en_q));
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("Masked view wrong.");

    // An enable-set write adds its bits and keeps the others.
    property p_en_set;
        @(posedge mclk_in) disable iff (sys_rst_in)
        commit && pwrite_in && paddr_in == `ADCAI_OFS_IRQ_EN_SET && pstrb_in == 4'hF
        |=> en_q == ($past(en_q) | $past(pwdata_in[11:0]));
    endproperty
    a_en_set: assert property (p_en_set) else $error("Enable set failed.");

    // An enable-clear write removes its bits.
    property p_en_clr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        commit && pwrite_in && paddr_in == `ADCAI_OFS_IRQ_EN_CLR && pstrb_in == 4'hF
        |=> (en_q & $past(pwdata_in[11:0])) == 12'h000;
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("Enable clear failed.");

    // The factor never holds a code outside the seven supported ones, 0 to 6.
    property p_factor_legal;
        @(posedge mclk_in) disable iff (sys_rst_in)
        factor_q <= `ADCAI_FACT_MAX;
    endproperty
    a_factor_legal: assert property (p_factor_legal) else $error("Illegal factor held.");

    // An unmapped address answers with an error.
    property p_unmapped;
        @(posedge mclk_in) disable iff (sys_rst_in)
        state_q == adcai_pkg::ST_IDLE && psel_in && penable_in && adcai_decode(paddr_in) == 8'h00
        |=> pready_q && pslverr_q;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not flagged.");

    c_clear_write: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
        commit && pwrite_in && paddr_in == `ADCAI_OFS_IRQ_CLR);
endmodule

// file: logic/adcai_defines.svh
// Register offsets, field positions and reset values of the averaging and interrupt block.
//----------------------------------------------------------------------------------------
//----------------------------------------------------------------------------------------
`ifndef ADCAI_DEFINES_SVH
`define ADCAI_DEFINES_SVH

// Register byte offsets.
`define ADCAI_OFS_CTRL       8'h00
`define ADCAI_OFS_IRQ_EN     8'h04
`define ADCAI_OFS_IRQ_EN_SET 8'h08
`define ADCAI_OFS_IRQ_EN_CLR 8'h0C
`define ADCAI_OFS_RAW_STAT   8'h10
`define ADCAI_OFS_MSK_STAT   8'h14
`define ADCAI_OFS_IRQ_CLR    8'h18
`define ADCAI_OFS_STAT_VIEW  8'h1C

// Control register fields.
`define ADCAI_CTRL_FACT_LSB  0
`define ADCAI_CTRL_FACT_MSB  2
`define ADCAI_CTRL_VIEW_BIT  8
`define ADCAI_FACT_MAX       3'h6

// Interrupt source field positions.
`define ADCAI_SRC_DONE_LSB   0
`define ADCAI_SRC_DMA_LSB    4
`define ADCAI_SRC_CMP_LSB    8

// Reset values.
`define ADCAI_RST_FACT       3'h0
`define ADCAI_RST_VIEW       1'h0
`define ADCAI_RST_IRQ_EN     12'h000

`endif

// file: logic/adcai_pkg.sv
// Types shared by the averaging and interrupt block.
package adcai_pkg;

    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } adcai_bus_state_e;

    // Register decode vector, one bit per register.
    typedef logic [7:0] adcai_sel_t;

endpackage

// file: logic/adcai_avg.sv
// Hardware averaging of successive conversions ahead of the sequencer result FIFOs.
`timescale 1ns/1ns
module adcai_avg #(
    parameter int DATA_W = 12,
    parameter int CHAN_W = 5
) (
    input  wire logic              mclk_in,
    input  wire logic              sys_rst_in,
    input  wire logic [2:0]        factor_in,
    input  wire logic              conv_valid_in,
    input  wire logic [DATA_W-1:0] conv_data_in,
    input  wire logic [CHAN_W-1:0] conv_chan_in,
    input  wire logic [1:0]        conv_seq_in,
    output logic                   res_valid_out,
    output logic [DATA_W-1:0]      res_data_out,
    output logic [CHAN_W-1:0]      res_chan_out,
    output logic [1:0]             res_seq_out
);
    localparam int ACC_W = DATA_W + 6;

    logic [2:0]        code_q, code_d;
    logic [6:0]        count_q, count_d;
    logic [ACC_W-1:0]  acc_q, acc_d;
    logic [CHAN_W-1:0] chan_q, chan_d;
    logic              valid_q, valid_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic [CHAN_W-1:0] rchan_q, rchan_d;
    logic [1:0]        rseq_q, rseq_d;
    logic [6:0]        target;
    logic              start;
    logic [ACC_W-1:0]  acc_n;
    logic [6:0]        cnt_n;

    // Accumulates conversions and emits one result per completed group.
    always_comb begin
        target  = 7'(7'h01 << factor_in);
        start   = (factor_in != code_q) || (count_q == 7'h00) || (conv_chan_in != chan_q);
        acc_n   = (start ? '0 : acc_q) + ACC_W'(conv_data_in);
        cnt_n   = start ? 7'h01 : 7'(count_q + 7'h01);
        code_d  = factor_in;
        count_d = (factor_in != code_q) ? 7'h00 : count_q;
        acc_d   = acc_q;
        chan_d  = chan_q;
        valid_d = 1'b0;
        data_d  = data_q;
        rchan_d = rchan_q;
        rseq_d  = rseq_q;
        if (conv_valid_in) begin
            rchan_d = conv_chan_in;
            rseq_d  = conv_seq_in;
            if (factor_in == 3'h0) begin
                valid_d = 1'b1;
                data_d  = conv_data_in;
                count_d = 7'h00;
            end else if (cnt_n == target) begin
                valid_d = 1'b1;
                data_d  = DATA_W'(acc_n >> factor_in);
                count_d = 7'h00;
                acc_d   = '0;
            end else begin
                count_d = cnt_n;
                acc_d   = acc_n;
                chan_d  = conv_chan_in;
            end
        end
    end

    // Registers the accumulator and the result presented to the FIFO.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            code_q  <= 3'h0;
            count_q <= 7'h00;
            acc_q   <= '0;
            chan_q  <= '0;
            valid_q <= 1'b0;
            data_q  <= '0;
            rchan_q <= '0;
            rseq_q  <= 2'h0;
        end else begin
            code_q  <= code_d;
            count_q <= count_d;
            acc_q   <= acc_d;
            chan_q  <= chan_d;
            valid_q <= valid_d;
            data_q  <= data_d;
            rchan_q <= rchan_d;
            rseq_q  <= rseq_d;
        end
    end

    assign res_valid_out = valid_q;
    assign res_data_out  = data_q;
    assign res_chan_out  = rchan_q;
    assign res_seq_out   = rseq_q;

    // Checks of the averaging behaviour.
    property p_avg_off;
        @(posedge mclk_in) disable iff (sys_rst_in)
        conv_valid_in && factor_in == 3'h0 |=> valid_q && data_q == $past(conv_data_in);
    endproperty
    a_avg_off: assert property (p_avg_off) else $error("Unaveraged sample not passed.");

    property p_avg_rate;
        @(posedge mclk_in) disable iff (sys_rst_in)
        conv_valid_in && factor_in != 3'h0 && factor_in == code_q && count_q != 7'h00 &&
        conv_chan_in == chan_q && count_q == 7'(target - 7'h01) |=> valid_q;
    endproperty
    a_avg_rate: assert property (p_avg_rate) else $error("Group end gave no result.");

    property p_avg_one_push;
        @(posedge mclk_in) disable iff (sys_rst_in)
        !conv_valid_in |=> !valid_q;
    endproperty
    a_avg_one_push: assert property (p_avg_one_push) else $error("Push without sample.");

    property p_avg_range;
        @(posedge mclk_in) disable iff (sys_rst_in)
        count_q < 7'h40;
    endproperty
    a_avg_range: assert property (p_avg_range) else $error("Group count overran 64.");

    c_avg_64: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
        valid_q && code_q == 3'h6);
endmodule

// file: logic/adcai_irq.sv
// Pending flags, masking and the single interrupt output.
`timescale 1ns/1ns
module adcai_irq #(
    parameter int N_SRC = 12
) (
    input  wire logic             mclk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [N_SRC-1:0] evt_in,
    input  wire logic [N_SRC-1:0] clr_in,
    input  wire logic [N_SRC-1:0] en_in,
    output logic [N_SRC-1:0]      pending_out,
    output logic                  irq_out
);
    logic [N_SRC-1:0] pend_q, pend_d;
    logic             irq_q, irq_d;

    // A fresh event overrides a clear that lands in the same cycle.
    always_comb begin
        pend_d = (pend_q & ~clr_in) | evt_in;
        irq_d  = |(pend_q & en_in);
    end

    // Registers the flags and the interrupt line.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            pend_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            pend_q <= pend_d;
            irq_q  <= irq_d;
        end
    end

    assign pending_out = pend_q;
    assign irq_out     = irq_q;

    // Checks of flag and line behaviour.
    property p_evt_kept;
        @(posedge mclk_in) disable iff (sys_rst_in)
        |evt_in |=> (pend_q & $past(evt_in)) == $past(evt_in);
    endproperty
    a_evt_kept: assert property (p_evt_kept) else $error("Event lost.");

    property p_clr_works;
        @(posedge mclk_in) disable iff (sys_rst_in)
        |(clr_in & ~evt_in) |=> (pend_q & $past(clr_in & ~evt_in)) == '0;
    endproperty
    a_clr_works: assert property (p_clr_works) else $error("Clear ignored.");

    property p_irq_masked;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (pend_q & en_in) == '0 |=> !irq_q;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("Disabled source raised line.");

    property p_clr_drops;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (pend_q & en_in) != '0 && (pend_q & en_in & ~clr_in) == '0 && evt_in == '0
        |=> (pend_q & en_in) == '0 ##1 !irq_q;
    endproperty
    a_clr_drops: assert property (p_clr_drops) else $error("Line held after clear.");

    c_collide: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
        |(evt_in & clr_in & pend_q));
    c_irq_rise: cover property (@(posedge mclk_in) disable iff (sys_rst_in) $rose(irq_q));
endmodule

// file: sim/adcai_sink_model.sv
// Far-side model: interrupt controller and FIFO sink that count what the block delivers.
`timescale 1ns/1ns
module adcai_sink_model (
    input  wire logic        mclk_in,
    input  wire logic        push_in,
    input  wire logic [11:0] data_in,
    input  wire logic        irq_in,
    output int               pushes_out,
    output logic [11:0]      last_out,
    output int               irq_edges_out
);
    logic irq_q;
    // Each push is one whole result; the interrupt line is seen on its rising edges.
    always @(posedge mclk_in) begin
        irq_q <= irq_in;
        if (irq_in === 1'b1 && irq_q !== 1'b1) irq_edges_out <= irq_edges_out + 1;
        if (push_in === 1'b1) begin
            pushes_out <= pushes_out + 1;
            last_out   <= data_in;
        end
    end
    initial begin
        pushes_out    = 0;
        irq_edges_out = 0;
        irq_q         = 1'b0;
        last_out      = 12'h000;
    end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the averaging and interrupt control block.
`timescale 1ns/1ns
`include "adcai_defines.svh"
module testbench;
    logic mclk_in = 0, sys_rst_in = 1, psel = 0, pen = 0, pwr = 0, cv = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, push, irq, e;
    logic [11:0] cd = 12'h000, fd, last;
    logic [4:0] cc = 5'h00, fc;
    logic [1:0] cs = 2'h0, fs;
    logic [3:0] de = 4'h0, dm = 4'h0, ce = 4'h0;
    int n_fail = 0, cmp_count = 0, pushes, irqs;
    adcai_top uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .conv_valid_in(cv), .conv_data_in(cd), .conv_chan_in(cc), .conv_seq_in(cs),
        .done_evt_in(de), .dma_evt_in(dm), .cmp_evt_in(ce), .fifo_push_out(push),
        .fifo_data_out(fd), .fifo_chan_out(fc), .fifo_seq_out(fs), .irq_out(irq));
    adcai_sink_model sink (.mclk_in(mclk_in), .push_in(push), .data_in(fd), .irq_in(irq),
        .pushes_out(pushes), .last_out(last), .irq_edges_out(irqs));
    // Clock of 100 MHz.
    always #5 mclk_in = ~mclk_in;
    //--------------------------------------------------------------------------------
    // Shared tasks
    //--------------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        pen <= 1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; pen <= 0;
    endtask
    // Back-to-back conversions of one channel: value base + i * step.
    task automatic conv(input int n, input logic [11:0] base, input logic [11:0] step,
                        input logic [4:0] ch, input logic [1:0] sq);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_in);
            cv <= 1; cd <= base + 12'(i) * step; cc <= ch; cs <= sq;
        end
        @(posedge mclk_in);
        cv <= 0;
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    //--------------------------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------------------------
    task automatic t_reset;
        apb(0, `ADCAI_OFS_CTRL, 0); chk(r, 0);
        apb(0, `ADCAI_OFS_IRQ_EN, 0); chk(r, 0);
        apb(0, 8'h20, 0); chk(r, 0);
        chk(e, 1);
    endtask
    task automatic t_average;
        conv(3, 12'h064, 12'h064, 5'h02, 2'h3); chk(pushes, 3);
        chk(last, 12'h12C);
        apb(1, `ADCAI_OFS_CTRL, 2); apb(1, `ADCAI_OFS_CTRL, 7);
        apb(0, `ADCAI_OFS_CTRL, 0); chk(r, 2);
        conv(3, 12'h00A, 12'h00A, 5'h02, 2'h3); chk(pushes, 3);
        conv(1, 12'h029, 12'h000, 5'h02, 2'h3); chk(pushes, 4);
        chk({fs, last}, {2'h3, 12'h019});
        // A channel change drops the partial group and restarts with the new sample.
        conv(2, 12'h100, 12'h000, 5'h07, 2'h1);
        conv(4, 12'h008, 12'h008, 5'h02, 2'h0);
        chk(pushes, 5);
        chk({fs, fc, last}, {2'h0, 5'h02, 12'h014});
        // Factor codes 1 to 5: the mean of 16 + 2i over 2^c samples is 15 + 2^c.
        for (int c = 1; c <= 5; c++) begin
            apb(1, `ADCAI_OFS_CTRL, c);
            conv(1 << c, 12'h010, 12'h002, 5'h02, 2'h2);
            chk(pushes, 5 + c);
            chk(last, 12'(15 + (1 << c)));
        end
        apb(1, `ADCAI_OFS_CTRL, 6);
        conv(64, 12'h000, 12'h001, 5'h02, 2'h3); chk(pushes, 11);
        chk(last, 12'h01F);
        apb(1, `ADCAI_OFS_CTRL, 0);
    endtask
    task automatic t_irq;
        apb(1, `ADCAI_OFS_IRQ_CLR, 32'hFFF);
        apb(1, `ADCAI_OFS_IRQ_EN_SET, 32'h011);
        @(posedge mclk_in); de <= 4'hF; dm <= 4'hF; ce <= 4'hF;
        @(posedge mclk_in); de <= 0; dm <= 0; ce <= 0;
        apb(0, `ADCAI_OFS_RAW_STAT, 0); chk(r, 32'hFFF);
        apb(0, `ADCAI_OFS_MSK_STAT, 0); chk(r, 32'h011);
        chk({irq, 31'(irqs)}, {1'b1, 31'd1});
        apb(1, `ADCAI_OFS_CTRL, 32'h100);
        apb(0, `ADCAI_OFS_STAT_VIEW, 0); chk(r, 32'h011);
        apb(1, `ADCAI_OFS_IRQ_CLR, 32'h011);
        apb(0, `ADCAI_OFS_RAW_STAT, 0); chk(r, 32'hFEE);
        chk(irq, 0);
        apb(1, `ADCAI_OFS_IRQ_EN_CLR, 32'h001);
        apb(0, `ADCAI_OFS_IRQ_EN, 0); chk(r, 32'h010);
        dm <= 4'h1;
        apb(1, `ADCAI_OFS_IRQ_CLR, 32'h010);
        dm <= 4'h0;
        apb(0, `ADCAI_OFS_MSK_STAT, 0); chk({irq, r[30:0]}, {1'b1, 31'h010});
    endtask
    // Main sequence after 12 cycles of reset.
    initial begin
        repeat (12) @(posedge mclk_in);
        sys_rst_in <= 0;
        t_reset();
        t_average();
        t_irq();
        give_verdict();
    end
    // Watchdog that ends a hung run.
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_fail++;
        give_verdict();
    end
endmodule
